// File: pwr_wake_pkg.sv
// Shared constants and types for the power mode and wake controller
package pwr_wake_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int POR_TIME_NS = 2500000;
   localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_TIME_NS = 20000;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_W = 20;
   localparam int SETTLE_W = 12;
   localparam logic [11:0] RESTART_ADDR = 12'h00C;
   localparam logic [7:0] NO_OP_OPCODE = 8'hFF;

   // ==========================================================
   // Device registers
   localparam logic [7:0] VDC_ADDR = 8'h0C;
   localparam logic [7:0] SW2_ADDR = 8'h0D;
   localparam int VDC_EN_BIT = 0;
   localparam int VDC_LOW_BIT = 1;
   localparam int VDC_HIGH_BIT = 2;
   localparam int SW2_SRC_LSB = 2;
   localparam int SW2_LVL_BIT = 6;
   localparam logic [7:0] SW2_WR_MASK = 8'h5C;
   localparam logic [2:0] SW2_SRC_RESET = 3'h0;
   localparam logic SW2_LVL_RESET = 1'b0;
   localparam int SUPPLY_IRQ_BIT = 5;

   // Candidate wake pins: [2:0] port3[3:1], [10:3] port2[7:0], [11] port0[0], [12] port0[7]
   localparam logic [12:0] SEL_P2_LOW4 = 13'h0078;
   localparam logic [12:0] SEL_P2_ALL = 13'h07F8;
   localparam logic [12:0] SEL_P3 = 13'h0007;
   localparam logic [12:0] SEL_P3_P0 = 13'h1807;
   localparam logic [12:0] SEL_P3_P2 = 13'h003F;

   // ==========================================================
   // Controller registers
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] MASK_ADDR = 8'h01;
   localparam logic [7:0] STAT_ADDR = 8'h02;
   localparam int CTRL_HALT_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int CTRL_CLR_BIT = 2;
   localparam int MASK_GIE_BIT = 7;

   typedef enum logic [3:0] {
      DEV_DELAY = 4'h1,
      DEV_RUN = 4'h2,
      DEV_HALT = 4'h4,
      DEV_STOP = 4'h8
   } dev_state_t;

   typedef enum logic [3:0] {
      SEQ_IDLE = 4'h1,
      SEQ_MON_OFF = 4'h2,
      SEQ_NO_OP = 4'h4,
      SEQ_SLEEP = 4'h8
   } seq_state_t;
endpackage : pwr_wake_pkg

// File: pwr_link_if.sv
// Link between the core-side controller and the power/wake device
interface pwr_link_if;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic [7:0] instr;
   logic instr_valid;
   logic halt_req;
   logic stop_req;
   logic [5:0] irq_mask;
   logic irq_global_en;
   logic supply_irq_clear;
   logic core_reset;
   logic core_clk_en;
   logic pc_load;
   logic [11:0] restart_addr;
   logic irq_take;
   logic supply_irq_pending;
   logic halted;
   logic stopped;

   modport dev (
      input reg_addr, reg_wdata, reg_wr, reg_rd, instr, instr_valid, halt_req, stop_req,
      input irq_mask, irq_global_en, supply_irq_clear,
      output reg_rdata, core_reset, core_clk_en, pc_load, restart_addr, irq_take,
      output supply_irq_pending, halted, stopped
   );
   modport core (
      output reg_addr, reg_wdata, reg_wr, reg_rd, instr, instr_valid, halt_req, stop_req,
      output irq_mask, irq_global_en, supply_irq_clear,
      input reg_rdata, core_reset, core_clk_en, pc_load, restart_addr, irq_take,
      input supply_irq_pending, halted, stopped
   );
endinterface : pwr_link_if

// File: pwr_wake_dev.sv
// Power-on delay, sleep modes, stop wake logic and supply monitor
//
// Chosen here: the strobed register port.
module pwr_wake_dev
   import pwr_wake_pkg::*;
#(
   parameter int unsigned POR_LOAD = POR_CYCLES
)
(
   input wire logic sys_clk, // system clock
   input wire logic reset, // synchronous reset, high
   pwr_link_if.dev lk, // link to core side
   input wire logic power_good, // supply at good level
   input wire logic vdd_above_high, // high comparator
   input wire logic vdd_below_low, // low comparator
   output logic monitor_on, // powers the comparators
   output logic xtal_on, // crystal oscillator enable
   input wire logic [7:0] port0_in, // port 0 pin levels
   input wire logic [7:0] port2_in, // port 2 pin levels
   input wire logic [3:0] port3_in, // port 3 pin levels
   input wire logic [7:0] port0_is_out, // port 0 pin is output
   input wire logic [7:0] port2_is_out, // port 2 pin is output
   input wire logic [3:0] port3_is_out, // port 3 pin is output
   input wire logic wake_one_event, // first wake register event
   input wire logic wake_one_delay, // first wake register bit 5
   input wire logic wdt_timeout, // watchdog timeout pulse
   input wire logic ext_reset, // external reset request
   input wire logic [4:0] irq_other // requests 0 to 4
);
   // ==========================================================
   // State
   typedef struct packed {
      dev_state_t st;
      logic [POR_W-1:0] por_cnt;
      logic [SETTLE_W-1:0] settle_cnt;
      logic mon_en;
      logic hi;
      logic lo;
      logic supply_req;
      logic [2:0] src2;
      logic lvl;
      logic [7:0] rdata;
      logic pc_load;
   } dev_regs_t;

   localparam logic [POR_W-1:0] POR_FULL = POR_LOAD[POR_W-1:0];
   localparam logic [POR_W-1:0] POR_SKIP = 20'h00001;
   localparam logic [SETTLE_W-1:0] SETTLE_DONE = SETTLE_CYCLES[SETTLE_W-1:0];

   dev_regs_t q;
   dev_regs_t d;

   logic [12:0] cand;
   logic [12:0] cand_out;
   logic [12:0] sel;
   logic [12:0] live;
   logic use_nor;
   logic term;
   logic wake_two;
   logic settled;
   logic [5:0] pend;

   // ==========================================================
   // Second wake source
   assign cand = {port0_in[7], port0_in[0], port2_in, port3_in[3:1]};
   assign cand_out = {port0_is_out[7], port0_is_out[0], port2_is_out, port3_is_out[3:1]};

   always_comb
   begin
      sel = 13'h0000;
      use_nor = 1'b0;
      case (q.src2)
         3'h1: sel = SEL_P2_LOW4;
         3'h2: sel = SEL_P2_ALL;
         3'h3:
         begin
            sel = SEL_P3;
            use_nor = 1'b1;
         end
         3'h4: sel = SEL_P3;
         3'h5:
         begin
            sel = SEL_P3_P0;
            use_nor = 1'b1;
         end
         3'h6: sel = SEL_P3_P0;
         3'h7: sel = SEL_P3_P2;
         default: sel = 13'h0000; // Power-on only
      endcase
   end

   // Output pins forced neutral so the rest still form the gate
   assign live = sel & ~cand_out;
   assign term = use_nor ? ~|(cand & live) : ~&(cand | ~live);
   // With every selected pin driven out there is no source at all
   assign wake_two = (|live) && (term == q.lvl);

   assign settled = q.mon_en && (q.settle_cnt == SETTLE_DONE);
   assign pend = {q.supply_req, irq_other} & lk.irq_mask & {6{lk.irq_global_en}};

   // ==========================================================
   // Next state
   always_comb
   begin
      d = q;
      d.pc_load = 1'b0;
      d.rdata = 8'h00;

      if (lk.reg_rd && (lk.reg_addr == VDC_ADDR))
      begin
         d.rdata[VDC_EN_BIT] = q.mon_en;
         d.rdata[VDC_LOW_BIT] = q.lo;
         d.rdata[VDC_HIGH_BIT] = q.hi;
      end
      if (lk.reg_wr && (lk.reg_addr == VDC_ADDR))
      begin
         d.mon_en = lk.reg_wdata[VDC_EN_BIT];
      end
      else if (lk.reg_wr && (lk.reg_addr == SW2_ADDR))
      begin
         d.src2 = lk.reg_wdata[SW2_SRC_LSB +: 3];
         d.lvl = lk.reg_wdata[SW2_LVL_BIT];
      end

      // Flags stay clear until the comparators have settled
      if (!q.mon_en)
      begin
         d.settle_cnt = '0;
      end
      else if (q.settle_cnt != SETTLE_DONE)
      begin
         d.settle_cnt = q.settle_cnt + 1'b1;
      end
      d.hi = settled && vdd_above_high;
      d.lo = settled && vdd_below_low;

      if (lk.supply_irq_clear)
      begin
         d.supply_req = 1'b0;
      end
      if (q.lo && q.mon_en)
      begin
         d.supply_req = 1'b1;
      end

      case (q.st)
         DEV_DELAY:
         begin
            if (q.por_cnt > POR_SKIP)
            begin
               d.por_cnt = q.por_cnt - 1'b1;
            end
            else
            begin
               d.st = DEV_RUN;
               d.pc_load = 1'b1;
            end
         end
         DEV_RUN:
         begin
            if (lk.stop_req)
            begin
               d.st = DEV_STOP;
            end
            else if (lk.halt_req)
            begin
               d.st = DEV_HALT;
            end
         end
         DEV_HALT:
         begin
            if (|pend)
            begin
               d.st = DEV_RUN;
            end
         end
         DEV_STOP:
         begin
            if (wake_two || wake_one_event)
            begin
               d.st = DEV_DELAY;
               d.por_cnt = wake_one_delay ? POR_FULL : POR_SKIP;
            end
         end
         default:
         begin
            d.st = DEV_DELAY;
            d.por_cnt = POR_FULL;
         end
      endcase

      // Reset sources override every mode
      if (ext_reset)
      begin
         d.st = DEV_DELAY;
         d.por_cnt = POR_SKIP;
      end
      if (wdt_timeout || !power_good)
      begin
         d.st = DEV_DELAY;
         d.por_cnt = POR_FULL;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         q <= '{st: DEV_DELAY, por_cnt: POR_FULL, settle_cnt: '0, mon_en: 1'b0, hi: 1'b0,
                lo: 1'b0, supply_req: 1'b0, src2: SW2_SRC_RESET, lvl: SW2_LVL_RESET,
                rdata: 8'h00, pc_load: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign lk.reg_rdata = q.rdata;
   assign lk.core_reset = (q.st == DEV_DELAY);
   assign lk.core_clk_en = (q.st == DEV_RUN);
   assign lk.pc_load = q.pc_load;
   assign lk.restart_addr = RESTART_ADDR;
   assign lk.irq_take = (q.st != DEV_DELAY) && (q.st != DEV_STOP) && (|pend);
   assign lk.supply_irq_pending = q.supply_req;
   assign lk.halted = (q.st == DEV_HALT);
   assign lk.stopped = (q.st == DEV_STOP);
   assign monitor_on = q.mon_en;
   assign xtal_on = (q.st != DEV_STOP);
endmodule : pwr_wake_dev

// File: pwr_wake_core.sv
// Core-side controller: software registers and sleep entry sequencer
module pwr_wake_core
   import pwr_wake_pkg::*;
(
   input wire logic sys_clk, // system clock
   input wire logic reset, // synchronous reset, high
   pwr_link_if.core lk, // link to device
   input wire logic [7:0] sw_addr, // software address
   input wire logic [7:0] sw_wdata, // software write data
   input wire logic sw_wr, // write strobe
   input wire logic sw_rd, // read strobe
   output logic [7:0] sw_rdata // read data, cycle after strobe
);
   // ==========================================================
   // State
   typedef struct packed {
      seq_state_t st;
      logic to_stop;
      logic [5:0] mask_bits;
      logic gie;
      logic [7:0] rdata;
      logic fwd;
   } core_regs_t;

   core_regs_t q;
   core_regs_t d;
   logic dev_addr;
   logic ctrl_wr;

   assign dev_addr = (sw_addr == VDC_ADDR) || (sw_addr == SW2_ADDR);
   assign ctrl_wr = sw_wr && (sw_addr == CTRL_ADDR);

   always_comb
   begin
      d = q;
      d.rdata = 8'h00;
      d.fwd = sw_rd && dev_addr;
      if (sw_rd && (sw_addr == MASK_ADDR))
      begin
         d.rdata = {q.gie, 1'b0, q.mask_bits};
      end
      else if (sw_rd && (sw_addr == STAT_ADDR))
      begin
         d.rdata = {3'h0, lk.supply_irq_pending, lk.core_reset, lk.stopped, lk.halted,
                    (q.st != SEQ_IDLE)};
      end
      if (sw_wr && (sw_addr == MASK_ADDR))
      begin
         d.mask_bits = sw_wdata[5:0];
         d.gie = sw_wdata[MASK_GIE_BIT];
      end
      case (q.st)
         SEQ_IDLE:
         begin
            if (ctrl_wr && sw_wdata[CTRL_STOP_BIT])
            begin
               d.st = SEQ_MON_OFF;
               d.to_stop = 1'b1;
            end
            else if (ctrl_wr && sw_wdata[CTRL_HALT_BIT])
            begin
               d.st = SEQ_NO_OP;
               d.to_stop = 1'b0;
            end
         end
         SEQ_MON_OFF: d.st = SEQ_NO_OP;
         SEQ_NO_OP: d.st = SEQ_SLEEP;
         SEQ_SLEEP: d.st = SEQ_IDLE;
         default: d.st = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         q <= '{st: SEQ_IDLE, to_stop: 1'b0, mask_bits: 6'h00, gie: 1'b0, rdata: 8'h00, fwd: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================
   // Link drive; the sequencer owns the bus while it turns the monitor off
   always_comb
   begin
      if (q.st == SEQ_MON_OFF)
      begin
         lk.reg_addr = VDC_ADDR;
         lk.reg_wdata = 8'h00;
         lk.reg_wr = 1'b1;
         lk.reg_rd = 1'b0;
      end
      else
      begin
         lk.reg_addr = sw_addr;
         // Reserved bits of the wake register always go out as zero
         lk.reg_wdata = (sw_addr == SW2_ADDR) ? (sw_wdata & SW2_WR_MASK) : sw_wdata;
         lk.reg_wr = sw_wr && dev_addr;
         lk.reg_rd = sw_rd && dev_addr;
      end
   end

   assign lk.instr = NO_OP_OPCODE;
   assign lk.instr_valid = (q.st == SEQ_NO_OP);
   assign lk.halt_req = (q.st == SEQ_SLEEP) && !q.to_stop;
   assign lk.stop_req = (q.st == SEQ_SLEEP) && q.to_stop;
   // Monitor enable order is up to software; see mask register
   assign lk.irq_mask = q.mask_bits;
   assign lk.irq_global_en = q.gie;
   assign lk.supply_irq_clear = ctrl_wr && sw_wdata[CTRL_CLR_BIT];
   assign sw_rdata = q.fwd ? lk.reg_rdata : q.rdata;
endmodule : pwr_wake_core

// File: pwr_wake_properties.sv
// Assertions on the link between core controller and power/wake device
module pwr_wake_properties
   import pwr_wake_pkg::*;
#(
   parameter int unsigned POR_LOAD = POR_CYCLES
)
(
   input wire logic sys_clk, // clock
   input wire logic reset, // sync reset
   input wire logic instr_valid, // no-op issued
   input wire logic halt_req, // halt request
   input wire logic stop_req, // stop request
   input wire logic [5:0] irq_mask, // mask bits
   input wire logic irq_global_en, // global enable
   input wire logic core_reset, // core held
   input wire logic core_clk_en, // core clock
   input wire logic pc_load, // restart pulse
   input wire logic [11:0] restart_addr, // restart vector
   input wire logic irq_take, // interrupt taken
   input wire logic supply_irq_pending, // request 5
   input wire logic halted, // halt state
   input wire logic stopped // stop state
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // Length of each core reset run
   logic [POR_W-1:0] run_q;
   logic [POR_W-1:0] run_d;
   always_comb run_d = core_reset ? run_q + 1'b1 : '0;
   always_ff @(posedge sys_clk) run_q <= reset ? '0 : run_d;

   // ==========
   // Properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_sleep_ask;
      halt_req || stop_req;
   endsequence
   sequence s_wake_taken;
      halted && irq_take;
   endsequence
   chk_nop_first: assert property (s_sleep_ask |-> $past(instr_valid))
      else $error("sleep request without a no-op just before it");
   chk_halt_entry: assert property (halt_req && core_clk_en |=> halted && !core_clk_en)
      else $error("halt did not gate the core clock");
   chk_stop_entry: assert property (stop_req && core_clk_en |=> stopped && !core_clk_en)
      else $error("stop did not stop the core clock");
   chk_halt_exit: assert property (s_wake_taken |=> !halted)
      else $error("taken interrupt did not end halt");
   chk_stop_exit: assert property ($fell(stopped) |-> core_reset)
      else $error("stop ended without a reset");
   chk_restart_vector: assert property (pc_load |-> (restart_addr == 12'h00C) && !core_reset)
      else $error("restart not at the fixed vector");
   chk_release_load: assert property ($fell(core_reset) |-> ##[0:1] pc_load)
      else $error("reset release without restart pulse");
   // Short runs come from external reset and from stop wakes without the delay bit, which skip the delay
   chk_delay_length: assert property ($fell(core_reset) |-> (run_q <= 2) ||
      ((run_q + 1 >= POR_LOAD) && (run_q <= POR_LOAD + 1)))
      else $error("power-on delay of wrong length");
   chk_supply_vector: assert property (supply_irq_pending && irq_mask[5] && irq_global_en && core_clk_en
      |-> irq_take)
      else $error("enabled supply request not taken");
endmodule : pwr_wake_properties

// File: tb_top.sv
// Self-checking bench for the power mode and wake controller
module tb_top
   import pwr_wake_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned POR_SIM = 20;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] sw_addr = 8'h00;
   logic [7:0] sw_wdata = 8'h00;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [7:0] sw_rdata;
   logic power_good = 1'b1;
   logic vdd_above_high = 1'b0;
   logic vdd_below_low = 1'b0;
   logic monitor_on;
   logic xtal_on;
   logic [7:0] port0_in = 8'h00;
   logic [7:0] port2_in = 8'h00;
   logic [3:0] port3_in = 4'h0;
   logic [7:0] port2_is_out = 8'h00;
   logic wake_one_event = 1'b0;
   logic wake_one_delay = 1'b0;
   logic wdt_timeout = 1'b0;
   logic ext_reset = 1'b0;
   logic [4:0] irq_other = 5'h00;
   logic [12:0] sel [8] = '{13'h0000, SEL_P2_LOW4, SEL_P2_ALL, SEL_P3, SEL_P3, SEL_P3_P0, SEL_P3_P0, SEL_P3_P2};
   int n_fail = 0;
   int comparisons = 0;
   int k;

   always #2.5 sys_clk = ~sys_clk;

   pwr_link_if i_pwr_link_if ();
   pwr_wake_dev #(.POR_LOAD(POR_SIM)) i_pwr_wake_dev (.sys_clk, .reset, .lk(i_pwr_link_if.dev), .power_good,
      .vdd_above_high, .vdd_below_low, .monitor_on, .xtal_on, .port0_in, .port2_in, .port3_in,
      .port0_is_out(8'h00), .port2_is_out, .port3_is_out(4'h0), .wake_one_event, .wake_one_delay,
      .wdt_timeout, .ext_reset, .irq_other);
   pwr_wake_core i_pwr_wake_core (.sys_clk, .reset, .lk(i_pwr_link_if.core), .sw_addr, .sw_wdata, .sw_wr,
      .sw_rd, .sw_rdata);
   pwr_wake_properties #(.POR_LOAD(POR_SIM)) i_pwr_wake_properties (.sys_clk, .reset,
      .instr_valid(i_pwr_link_if.instr_valid), .halt_req(i_pwr_link_if.halt_req),
      .stop_req(i_pwr_link_if.stop_req), .irq_mask(i_pwr_link_if.irq_mask),
      .irq_global_en(i_pwr_link_if.irq_global_en), .core_reset(i_pwr_link_if.core_reset),
      .core_clk_en(i_pwr_link_if.core_clk_en), .pc_load(i_pwr_link_if.pc_load),
      .restart_addr(i_pwr_link_if.restart_addr), .irq_take(i_pwr_link_if.irq_take),
      .supply_irq_pending(i_pwr_link_if.supply_irq_pending), .halted(i_pwr_link_if.halted),
      .stopped(i_pwr_link_if.stopped));

   // ==========
   // Bus and check tasks
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge sys_clk);
      sw_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge sys_clk);
      sw_rd <= 1'b0;
      #1;
      check(name, sw_rdata, exp);
   endtask : rd

   task automatic wait_run;
      k = 0;
      while (i_pwr_link_if.core_clk_en !== 1'b1 && k < 200)
      begin
         tick(1);
         k++;
      end
      check("core running", i_pwr_link_if.core_clk_en, 1'b1);
   endtask : wait_run

   task automatic set_pins(input logic [12:0] v);
      port3_in <= {v[2:0], 1'b0};
      port2_in <= v[10:3];
      port0_in <= {v[12], 6'h00, v[11]};
   endtask : set_pins

   // Pins idle, enter stop, then apply wake pins and first-register inputs
   task automatic sleep_wake(input logic [2:0] code, input logic lvl, input logic [12:0] idle,
      input logic [12:0] go, input logic [1:0] ev, input logic woken);
      wait_run;
      wr(SW2_ADDR, {1'b0, lvl, 1'b0, code, 2'b00});
      set_pins(idle);
      wr(CTRL_ADDR, 8'h02);
      tick(6);
      check("stopped", i_pwr_link_if.stopped, 1'b1);
      check("xtal_on", xtal_on, 1'b0);
      check("monitor_on", monitor_on, 1'b0);
      set_pins(go);
      {wake_one_delay, wake_one_event} <= ev;
      tick(3);
      check("woken", !i_pwr_link_if.stopped, woken);
      tick(8);
      check("delay after wake", i_pwr_link_if.core_reset, ev[1]);
      {wake_one_delay, wake_one_event} <= 2'b00;
      if (!woken)
      begin
         ext_reset <= 1'b1;
         tick(1);
         ext_reset <= 1'b0;
         tick(2);
         check("stop left by reset", i_pwr_link_if.stopped, 1'b0);
      end
   endtask : sleep_wake

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   // ==========
   // Tests
   initial
   begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      k = 0;
      while (i_pwr_link_if.core_reset !== 1'b0 && k < 100)
      begin
         tick(1);
         k++;
      end
      check("por cycles", k >= POR_SIM - 1 && k <= POR_SIM + 2, 1'b1);
      check("restart addr", i_pwr_link_if.restart_addr, 12'h00C);
      check("no-op opcode", i_pwr_link_if.instr, 8'hFF);
      rd(VDC_ADDR, 8'h00, "monitor reset");
      rd(STAT_ADDR, 8'h00, "status idle");
      $display("Test power-on done");
      // Global enable first; a low supply at start-up latches its request even while masked
      wr(MASK_ADDR, 8'h80);
      rd(MASK_ADDR, 8'h80, "mask readback");
      vdd_below_low <= 1'b1;
      wr(VDC_ADDR, 8'h01);
      rd(VDC_ADDR, 8'h01, "flags masked");
      tick(3990);
      rd(VDC_ADDR, 8'h01, "flags still masked");
      tick(10);
      // Port mode left untouched while the low flag is checked
      rd(VDC_ADDR, 8'h03, "low flag");
      check("irq masked", i_pwr_link_if.irq_take, 1'b0);
      wr(MASK_ADDR, 8'hA0);
      tick(1);
      check("irq taken", i_pwr_link_if.irq_take, 1'b1);
      wr(MASK_ADDR, 8'h00);
      vdd_below_low <= 1'b0;
      vdd_above_high <= 1'b1;
      tick(2);
      rd(VDC_ADDR, 8'h05, "high flag");
      rd(STAT_ADDR, 8'h10, "request latched");
      wr(CTRL_ADDR, 8'h04);
      rd(STAT_ADDR, 8'h00, "request cleared");
      vdd_above_high <= 1'b0;
      $display("Test monitor done");
      wr(CTRL_ADDR, 8'h01);
      tick(4);
      check("halted", i_pwr_link_if.halted, 1'b1);
      check("halt clock", i_pwr_link_if.core_clk_en, 1'b0);
      check("halt xtal", xtal_on, 1'b1);
      irq_other <= 5'h01;
      tick(3);
      check("masked stays halted", i_pwr_link_if.halted, 1'b1);
      wr(MASK_ADDR, 8'h81);
      tick(3);
      check("halt left", i_pwr_link_if.halted, 1'b0);
      irq_other <= 5'h00;
      wr(MASK_ADDR, 8'h00);
      $display("Test halt done");
      for (int c = 0; c < 8; c++)
         sleep_wake(3'(c), 1'b0, ~sel[c], 13'h1FFF, 2'b00, c != 0);
      sleep_wake(3'h3, 1'b1, 13'h1FFF, 13'h0000, 2'b00, 1'b1);
      port2_is_out <= 8'h01;
      sleep_wake(3'h1, 1'b0, 13'h0000, 13'h0070, 2'b00, 1'b1);
      port2_is_out <= 8'h00;
      sleep_wake(3'h0, 1'b0, 13'h0000, 13'h0000, 2'b11, 1'b1);
      $display("Test stop done");
      wait_run;
      wdt_timeout <= 1'b1;
      tick(1);
      wdt_timeout <= 1'b0;
      tick(5);
      check("watchdog delay", i_pwr_link_if.core_reset, 1'b1);
      wait_run;
      power_good <= 1'b0;
      tick(2);
      power_good <= 1'b1;
      tick(5);
      check("supply delay", i_pwr_link_if.core_reset, 1'b1);
      wait_run;
      $display("Test triggers done");
      end_of_test();
   end

   // Whole run is near 4400 cycles; this allows ample margin
   initial
   begin
      #150000;
      n_fail++;
      end_of_test();
   end
endmodule : tb_top
